// [hdl/vdei_pkg.sv]
/*
 * Package for the decoder event issue block: register offsets, field positions,
 * event bit positions, command codes and state types.
 * Assumes an AHB-Lite bus with 32-bit data and a single slave.
 */
package vdei_pkg;
	// byte addresses: printed index 0xa is not a multiple of four, so address = 4 * index
	localparam logic [7:0] STATUS_IDX = 8'h0A;
	localparam logic [7:0] STATUS_ADDR = 8'h28;
	localparam logic [7:0] CMD_ADDR = 8'h00;
	localparam logic [7:0] MASK_ADDR = 8'h04;
	localparam logic [7:0] CTRL_ADDR = 8'h08;
	localparam logic [7:0] STATE_ADDR = 8'h0C;
	localparam logic [7:0] PKT_ADDR = 8'h10;
	// event positions in mask and status
	localparam int RDY_BIT = 10;
	localparam int SCN_BIT = 11;
	localparam int SEQD_BIT = 9;
	localparam int SEQV_BIT = 3;
	localparam int UND_BIT = 8;
	// command register codes
	localparam logic [3:0] CMD_SET_MASK = 4'h1;
	localparam logic [3:0] CMD_ANNOUNCE = 4'h2;
	localparam logic [3:0] CMD_DISCARD = 4'h3;
	localparam logic [3:0] CMD_SCAN = 4'h4;
	localparam logic [3:0] CMD_PLAY = 4'h5;
	localparam logic [3:0] CMD_IDLE = 4'h6;
	// ctrl register fields
	localparam int CTRL_WP_BIT = 0;
	localparam int CTRL_IRQ_BIT = 1;
	localparam logic [15:0] RESET_MASK = 16'h0000;
	localparam logic [31:0] PKT_BIAS = 32'h0000_0006;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {VDEI_IDLE, VDEI_PLAY, VDEI_SCAN, VDEI_PAUSE} vdei_mode_t;

	// decoder-side event strobes
	typedef struct packed {
		logic pic_done;
		logic pic_is_i;
		logic seq_hdr;
		logic seq_end;
		logic vsync_rise;
		logic next_field_new_i;
		logic need_word;
		logic buf_empty;
		logic row_poll;
		logic free_ge_thresh;
		logic data_byte;
	} vdei_dec_t;

	typedef struct packed {
		logic [1:0] htrans;
		logic hwrite;
		logic [7:0] addr;
		logic ph;
		logic [15:0] mask;
		logic [15:0] mask_pend;
		logic mask_req;
		logic [15:0] status;
		logic [15:0] queue;
		logic irq;
		logic wp;
		vdei_mode_t mode;
		logic hdr_pend;
		logic pkt_seen;
		logic [31:0] pkt_sum;
		logic [31:0] rx_bytes;
		logic consume;
		logic param_wr;
		logic [31:0] rdata;
	} vdei_state_t;
endpackage

// [hdl/vdei_top.sv]
/*
 * Decoder event detection, issue and queuing, with an AHB-Lite register slave.
 * Assumes decoder strobes are synchronous to hclk and one cycle wide.
 */
// The AHB-Lite slave port was left to the implementer.
// Functional notes
// - scan-complete raised when an I-picture finishes in scan state, mask bit 11.
// - scan-complete moves scan to pause and stops bitstream consumption.
// - header-decoded raised on each sequence header outside idle, mask bit 9.
// - sequence parameters rewritten on header outside idle unless write protect is one.
// - header-displayed signalled on vsync rise before first new I-field, mask bit 3.
// - header-pending set on header, cleared by idle, discard, end code, event.
// - header-displayed needs vsync, new I-picture, pending flag and mask bit.
// - buffer-empty raised when buffer empty and word needed, mask bit 8.
// - buffer-empty is level sensitive and repeats while empty.
// - packet announces never suppress buffer-empty.
// - mask command takes effect only after a whole picture decodes.
// - each event is delivered at once or queued.
// - delivery only while status is zero; sets pin and event bit.
// - nonzero status holds new events in the queue.
// - lone delivery sets only that event's bit.
// - queue examined at every display-time poll; queued ready still delivered.
// - fullness sampled for ready only at row poll points.
// - packet announce falsifies the ready byte-count precondition.
// - pin left unchanged unless status is zero.
// - ready needs received bytes at least announced sum minus six.
module vdei_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire vdei_pkg::vdei_dec_t dec,
	output logic irq_pin,
	output logic consume_en,
	output logic param_write,
	output logic [1:0] dec_mode
);
	vdei_pkg::vdei_state_t s_q, s_d;
	logic [15:0] ev;
	logic [15:0] all_ev;
	logic rdy_ok;
	logic wr_ph;

	always_comb begin
		s_d = s_q;
		ev = '0;
		wr_ph = s_q.ph && s_q.hwrite;
		s_d.param_wr = 1'b0;
		// address phase capture
		s_d.ph = hsel && hready && (htrans == vdei_pkg::HTRANS_NONSEQ);
		if (hsel && hready) begin
			s_d.hwrite = hwrite;
			s_d.addr = haddr[7:0];
		end
		// host side writes
		if (wr_ph) begin
			unique case (s_q.addr)
				vdei_pkg::CMD_ADDR: begin
					unique case (hwdata[3:0])
						vdei_pkg::CMD_SET_MASK: begin
							s_d.mask_pend = hwdata[31:16];
							s_d.mask_req = 1'b1;
						end
						vdei_pkg::CMD_ANNOUNCE: begin
							// bumping the sum makes the byte-count test false
							s_d.pkt_sum = s_q.pkt_sum + {16'h0000, hwdata[31:16]};
							s_d.pkt_seen = 1'b1;
						end
						vdei_pkg::CMD_DISCARD: begin
							s_d.pkt_sum = '0;
							s_d.rx_bytes = '0;
							s_d.pkt_seen = 1'b0;
							s_d.hdr_pend = 1'b0;
						end
						vdei_pkg::CMD_SCAN: s_d.mode = vdei_pkg::VDEI_SCAN;
						vdei_pkg::CMD_PLAY: s_d.mode = vdei_pkg::VDEI_PLAY;
						vdei_pkg::CMD_IDLE: begin
							s_d.mode = vdei_pkg::VDEI_IDLE;
							s_d.hdr_pend = 1'b0;
							s_d.pkt_sum = '0;
							s_d.rx_bytes = '0;
							s_d.pkt_seen = 1'b0;
						end
						default: ;
					endcase
				end
				vdei_pkg::STATUS_ADDR: s_d.status = hwdata[15:0];
				vdei_pkg::CTRL_ADDR: begin
					s_d.wp = hwdata[vdei_pkg::CTRL_WP_BIT];
					s_d.irq = hwdata[vdei_pkg::CTRL_IRQ_BIT];
				end
				default: ;
			endcase
		end
		if (dec.data_byte) begin
			s_d.rx_bytes = s_d.rx_bytes + 32'h0000_0001;
		end
		// decode-time events
		if (dec.pic_done && dec.pic_is_i && s_q.mode == vdei_pkg::VDEI_SCAN) begin
			ev[vdei_pkg::SCN_BIT] = s_q.mask[vdei_pkg::SCN_BIT];
			s_d.mode = vdei_pkg::VDEI_PAUSE;
		end
		if (dec.seq_hdr && s_q.mode != vdei_pkg::VDEI_IDLE) begin
			ev[vdei_pkg::SEQD_BIT] = s_q.mask[vdei_pkg::SEQD_BIT];
			s_d.param_wr = !s_q.wp;
			s_d.hdr_pend = 1'b1;
		end
		if (dec.seq_end) begin
			s_d.hdr_pend = 1'b0;
		end
		// vsync event, conditions all together
		if (dec.vsync_rise && dec.next_field_new_i && s_q.hdr_pend) begin
			ev[vdei_pkg::SEQV_BIT] = s_q.mask[vdei_pkg::SEQV_BIT];
			s_d.hdr_pend = 1'b0;
		end
		// level sensitive: no edge detect, announce plays no part
		ev[vdei_pkg::UND_BIT] = dec.buf_empty && dec.need_word
			&& s_q.mask[vdei_pkg::UND_BIT];
		// fullness only looked at on row polls
		rdy_ok = dec.row_poll && dec.free_ge_thresh && s_q.pkt_seen
			&& (s_q.rx_bytes + vdei_pkg::PKT_BIAS >= s_q.pkt_sum);
		ev[vdei_pkg::RDY_BIT] = rdy_ok && s_q.mask[vdei_pkg::RDY_BIT];
		// low priority: mask lands only at picture end
		if (s_q.mask_req && dec.pic_done) begin
			s_d.mask = s_q.mask_pend;
			s_d.mask_req = 1'b0;
		end
		// issue or queue; queued items flush at a poll point
		all_ev = ev | s_q.queue;
		if (s_d.status == '0 && (dec.row_poll || s_q.queue == '0) && all_ev != '0) begin
			s_d.status = all_ev;
			s_d.irq = 1'b1;
			s_d.queue = '0;
		end else begin
			s_d.queue = s_q.queue | ev;
		end
		s_d.consume = (s_d.mode == vdei_pkg::VDEI_PLAY) || (s_d.mode == vdei_pkg::VDEI_SCAN);
		unique case (haddr[7:0])
			vdei_pkg::STATUS_ADDR: s_d.rdata = {16'h0000, s_d.status};
			vdei_pkg::MASK_ADDR: s_d.rdata = {16'h0000, s_q.mask};
			vdei_pkg::CTRL_ADDR: s_d.rdata = {30'h0, s_q.irq, s_q.wp};
			vdei_pkg::STATE_ADDR: s_d.rdata = {14'h0, s_q.queue, s_q.mode};
			vdei_pkg::PKT_ADDR: s_d.rdata = s_q.pkt_sum;
			default: s_d.rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{mode: vdei_pkg::VDEI_IDLE, mask: vdei_pkg::RESET_MASK, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq_pin = s_q.irq;
	assign consume_en = s_q.consume;
	assign param_write = s_q.param_wr;
	assign dec_mode = s_q.mode;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// mode and consumption
	scan_to_pause_a: assert property (
		dec.pic_done && dec.pic_is_i && s_q.mode == vdei_pkg::VDEI_SCAN
		|=> s_q.mode == vdei_pkg::VDEI_PAUSE && !consume_en)
		else $error("scan did not pause");

	pause_stop_a: assert property (
		s_q.mode == vdei_pkg::VDEI_PAUSE |-> !consume_en)
		else $error("pause still consuming");

	play_run_a: assert property (
		s_q.mode == vdei_pkg::VDEI_PLAY |-> consume_en)
		else $error("play not consuming");

	// a scan command with no picture finishing in the same cycle must enter scan mode
	scan_cmd_a: assert property (
		wr_ph && s_q.addr == vdei_pkg::CMD_ADDR && hwdata[3:0] == vdei_pkg::CMD_SCAN
		&& !dec.pic_done
		|=> s_q.mode == vdei_pkg::VDEI_SCAN && consume_en)
		else $error("scan command ignored");

	idle_cmd_a: assert property (
		wr_ph && s_q.addr == vdei_pkg::CMD_ADDR && hwdata[3:0] == vdei_pkg::CMD_IDLE
		&& !dec.pic_done && !dec.seq_hdr
		|=> s_q.mode == vdei_pkg::VDEI_IDLE && !consume_en && !s_q.hdr_pend)
		else $error("idle command ignored");

	// scan-complete delivery
	scan_issue_a: assert property (
		dec.pic_done && dec.pic_is_i && s_q.mode == vdei_pkg::VDEI_SCAN
		&& s_q.mask[vdei_pkg::SCN_BIT] && s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> s_q.status[vdei_pkg::SCN_BIT])
		else $error("scan event missed");

	scan_masked_a: assert property (
		!s_q.mask[vdei_pkg::SCN_BIT] && s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> !s_q.status[vdei_pkg::SCN_BIT])
		else $error("masked scan event issued");

	// header decoded and parameter write
	hdr_issue_a: assert property (
		dec.seq_hdr && s_q.mode != vdei_pkg::VDEI_IDLE && s_q.mask[vdei_pkg::SEQD_BIT]
		&& s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> s_q.status[vdei_pkg::SEQD_BIT])
		else $error("header event missed");

	hdr_masked_a: assert property (
		!s_q.mask[vdei_pkg::SEQD_BIT] && s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> !s_q.status[vdei_pkg::SEQD_BIT])
		else $error("masked header event issued");

	// no decoding goes on while idle, so a header there is not an event
	hdr_idle_a: assert property (
		dec.seq_hdr && s_q.mode == vdei_pkg::VDEI_IDLE
		&& s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> !s_q.status[vdei_pkg::SEQD_BIT])
		else $error("header event while idle");

	wp_blocks_a: assert property (
		param_write |-> !$past(s_q.wp))
		else $error("protected write");

	param_go_a: assert property (
		dec.seq_hdr && s_q.mode != vdei_pkg::VDEI_IDLE && !s_q.wp
		|=> param_write)
		else $error("parameter write missed");

	param_quiet_a: assert property (
		!dec.seq_hdr |=> !param_write)
		else $error("stray parameter write");

	// header pending flag
	pend_set_a: assert property (
		dec.seq_hdr && s_q.mode != vdei_pkg::VDEI_IDLE && !dec.seq_end && !dec.vsync_rise
		|=> s_q.hdr_pend)
		else $error("pending not set");

	pend_clear_a: assert property (
		dec.seq_end && !dec.seq_hdr |=> !s_q.hdr_pend)
		else $error("pending not cleared");

	pend_shown_a: assert property (
		dec.vsync_rise && dec.next_field_new_i && s_q.hdr_pend && !dec.seq_hdr
		|=> !s_q.hdr_pend)
		else $error("pending kept after show");

	discard_clear_a: assert property (
		wr_ph && s_q.addr == vdei_pkg::CMD_ADDR && hwdata[3:0] == vdei_pkg::CMD_DISCARD
		&& !dec.seq_hdr
		|=> !s_q.hdr_pend && s_q.pkt_sum == '0)
		else $error("discard left state");

	// header displayed
	shown_issue_a: assert property (
		dec.vsync_rise && dec.next_field_new_i && s_q.hdr_pend
		&& s_q.mask[vdei_pkg::SEQV_BIT] && s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> s_q.status[vdei_pkg::SEQV_BIT])
		else $error("shown event missed");

	shown_masked_a: assert property (
		!s_q.mask[vdei_pkg::SEQV_BIT] && s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> !s_q.status[vdei_pkg::SEQV_BIT])
		else $error("masked shown event issued");

	// every condition must have held in the cycle before the bit appears
	shown_needs_a: assert property (
		s_q.status == '0 && !s_q.queue[vdei_pkg::SEQV_BIT] && !wr_ph
		|=> !s_q.status[vdei_pkg::SEQV_BIT] || $past(dec.vsync_rise
		&& dec.next_field_new_i && s_q.hdr_pend && s_q.mask[vdei_pkg::SEQV_BIT]))
		else $error("shown event without cause");

	// buffer empty
	und_repeat_a: assert property (
		s_q.status == '0 && s_q.queue == '0 && dec.buf_empty && dec.need_word
		&& s_q.mask[vdei_pkg::UND_BIT] && !wr_ph
		|=> s_q.status[vdei_pkg::UND_BIT])
		else $error("empty event missed");

	und_masked_a: assert property (
		!s_q.mask[vdei_pkg::UND_BIT] && s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> !s_q.status[vdei_pkg::UND_BIT])
		else $error("masked empty event issued");

	// a packet announce in the same cycle must not hold the event back
	und_announce_a: assert property (
		s_q.status == '0 && s_q.queue == '0 && dec.buf_empty && dec.need_word
		&& s_q.mask[vdei_pkg::UND_BIT] && wr_ph && s_q.addr == vdei_pkg::CMD_ADDR
		|=> s_q.status[vdei_pkg::UND_BIT])
		else $error("announce hid empty event");

	// level, not edge: a second empty cycle while busy is queued again
	und_level_a: assert property (
		s_q.status != '0 && dec.buf_empty && dec.need_word && s_q.mask[vdei_pkg::UND_BIT]
		&& !wr_ph
		|=> s_q.queue[vdei_pkg::UND_BIT])
		else $error("repeat empty event dropped");

	// mask command timing
	mask_late_a: assert property (
		!dec.pic_done |=> s_q.mask == $past(s_q.mask))
		else $error("mask changed mid picture");

	mask_take_a: assert property (
		s_q.mask_req && dec.pic_done |=> s_q.mask == $past(s_q.mask_pend))
		else $error("mask not applied");

	// issue and queue
	queue_keep_a: assert property (
		s_q.status != '0 && !wr_ph && s_q.queue != '0
		|=> s_q.queue != '0)
		else $error("queued event lost");

	issue_or_queue_a: assert property (
		1'b1 |=> ((s_q.status | s_q.queue) & $past(ev)) == $past(ev))
		else $error("event neither issued nor queued");

	issue_pin_a: assert property (
		(s_q.status == '0 && !wr_ph) ##1 s_q.status != '0 |-> irq_pin)
		else $error("pin not raised on issue");

	hold_busy_a: assert property (
		s_q.status != '0 && !wr_ph |=> s_q.status == $past(s_q.status))
		else $error("status changed while busy");

	busy_queue_a: assert property (
		s_q.status != '0 && !wr_ph |=> (s_q.queue & $past(ev)) == $past(ev))
		else $error("busy event not queued");

	lone_bit_a: assert property (
		s_q.status == '0 && s_q.queue == '0 && !wr_ph
		|=> (s_q.status & ~$past(ev)) == '0)
		else $error("extra status bit");

	poll_flush_a: assert property (
		s_q.status == '0 && dec.row_poll && !wr_ph
		|=> s_q.status == $past(s_q.queue | ev) && s_q.queue == '0)
		else $error("queue not flushed at poll");

	// ready for data
	rdy_poll_a: assert property (
		!dec.row_poll && s_q.status == '0 && !s_q.queue[vdei_pkg::RDY_BIT] && !wr_ph
		|=> !s_q.status[vdei_pkg::RDY_BIT])
		else $error("ready outside poll");

	rdy_count_a: assert property (
		dec.row_poll && !s_q.queue[vdei_pkg::RDY_BIT] && s_q.status == '0 && !wr_ph
		&& (!s_q.pkt_seen || s_q.rx_bytes + vdei_pkg::PKT_BIAS < s_q.pkt_sum)
		|=> !s_q.status[vdei_pkg::RDY_BIT])
		else $error("ready despite announce");

	rdy_issue_a: assert property (
		dec.row_poll && dec.free_ge_thresh && s_q.pkt_seen
		&& s_q.rx_bytes + vdei_pkg::PKT_BIAS >= s_q.pkt_sum
		&& s_q.mask[vdei_pkg::RDY_BIT] && s_q.status == '0 && !wr_ph
		|=> s_q.status[vdei_pkg::RDY_BIT])
		else $error("ready event missed");

	rdy_masked_a: assert property (
		!s_q.mask[vdei_pkg::RDY_BIT] && s_q.status == '0 && !s_q.queue[vdei_pkg::RDY_BIT]
		&& !wr_ph
		|=> !s_q.status[vdei_pkg::RDY_BIT])
		else $error("masked ready issued");

	announce_seen_a: assert property (
		wr_ph && s_q.addr == vdei_pkg::CMD_ADDR && hwdata[3:0] == vdei_pkg::CMD_ANNOUNCE
		|=> s_q.pkt_seen)
		else $error("announce not recorded");

	// pin
	pin_hold_a: assert property (
		s_q.status != '0 && !wr_ph |=> irq_pin == $past(irq_pin))
		else $error("pin changed while busy");

	// bus side
	read_status_a: assert property (
		s_q.ph && !s_q.hwrite && s_q.addr == vdei_pkg::STATUS_ADDR
		|-> hrdata == {16'h0000, s_q.status})
		else $error("status read wrong");

	read_mask_a: assert property (
		s_q.ph && !s_q.hwrite && s_q.addr == vdei_pkg::MASK_ADDR
		|-> hrdata == {16'h0000, $past(s_q.mask)})
		else $error("mask read wrong");

	bus_okay_a: assert property (
		hreadyout && !hresp)
		else $error("bus stalled or failed");

	scn_cov: cover property (s_q.status[vdei_pkg::SCN_BIT]);
	rdy_cov: cover property (s_q.queue[vdei_pkg::RDY_BIT] ##[1:50] s_q.status[vdei_pkg::RDY_BIT]);
	seqv_cov: cover property (s_q.status[vdei_pkg::SEQV_BIT]);
	und_cov: cover property (s_q.status[vdei_pkg::UND_BIT] && s_q.queue[vdei_pkg::UND_BIT]);
	mask_cov: cover property (s_q.mask_req ##1 !s_q.mask_req);
endmodule

// [tb/tb.sv]
/*
 * Bench for the event issue block: register access through the host model,
 * decoder strobes driven here. Assumes zero-wait slave and one clock.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ST = vdei_pkg::STATUS_ADDR;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irq_pin, consume_en, param_write;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, dec_mode;
	logic [2:0] hsize;
	vdei_pkg::vdei_dec_t dec = '0;
	vdei_pkg::vdei_dec_t lvl = '0;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #5 hclk = ~hclk;
	vdei_top vdei_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.dec(dec), .irq_pin(irq_pin), .consume_en(consume_en),
		.param_write(param_write), .dec_mode(dec_mode));
	vdei_host_model vdei_host_model_inst (.hclk(hclk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			conclude();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		vdei_host_model_inst.xfer(1'b0, a, 32'h00000000, rd);
		chk(n, e, rd);
	endtask
	task automatic cmd(input logic [3:0] c, input logic [15:0] arg);
		vdei_host_model_inst.xfer(1'b1, vdei_pkg::CMD_ADDR, {arg, 12'h000, c}, rd);
	endtask
	// one-cycle strobe on top of the held levels; bit order follows the struct
	task automatic strobe(input vdei_pkg::vdei_dec_t v);
		dec <= v | lvl;
		@(posedge hclk);
		dec <= lvl;
		@(posedge hclk);
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("irq at reset", 32'h0, {31'h0, irq_pin});
		rdchk("status at reset", ST, 32'h0);
		rdchk("unmapped", 8'h3C, 32'h0);
		cmd(vdei_pkg::CMD_SET_MASK, 16'h0B08);
		rdchk("mask before picture", vdei_pkg::MASK_ADDR, 32'h0);
		strobe(11'h400);
		rdchk("mask", vdei_pkg::MASK_ADDR, 32'h0B08);
		cmd(vdei_pkg::CMD_SCAN, 16'h0000);
		strobe(11'h400);
		chk("scan mode", 32'h2, {30'h0, dec_mode});
		strobe(11'h600);
		rdchk("scan done", ST, 32'h800);
		chk("pause", 32'h7, {28'h0, consume_en, irq_pin, dec_mode});
		strobe(11'h100);
		chk("param write", 32'h1, {31'h0, param_write});
		rdchk("held while busy", ST, 32'h800);
		vdei_host_model_inst.service();
		chk("pin after service", 32'h0, {31'h0, irq_pin});
		strobe(11'h004);
		rdchk("queued header", ST, 32'h200);
		vdei_host_model_inst.service();
		strobe(11'h060);
		rdchk("header shown", ST, 32'h8);
		vdei_host_model_inst.service();
		strobe(11'h060);
		rdchk("flag cleared", ST, 32'h0);
		lvl = 11'h018;
		strobe(11'h000);
		rdchk("empty", ST, 32'h100);
		cmd(vdei_pkg::CMD_ANNOUNCE, 16'h0040);
		vdei_host_model_inst.service();
		strobe(11'h004);
		rdchk("still empty", ST, 32'h100);
		vdei_host_model_inst.xfer(1'b1, vdei_pkg::CTRL_ADDR, 32'h00000001, rd);
		strobe(11'h100);
		chk("protected param", 32'h0, {31'h0, param_write});
		rdchk("ctrl", vdei_pkg::CTRL_ADDR, 32'h1);
		chk("okay resp", 32'h0, {31'h0, hresp});
		conclude();
	end
endmodule

// [tb/vdei_host_model.sv]
/*
 * Host model: AHB-Lite master tasks and the interrupt service order.
 * Assumes one slave whose hreadyout is fed back as hready.
 */
module vdei_host_model (
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
	end
	// entered just after a rising edge; returns at the edge that ends the data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= vdei_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// pin first: the block leaves the pin alone while status is nonzero
	task automatic service();
		logic [31:0] d;
		xfer(1'b1, vdei_pkg::CTRL_ADDR, 32'h00000000, d);
		xfer(1'b1, vdei_pkg::STATUS_ADDR, 32'h00000000, d);
	endtask
endmodule
